// File: hw/alarm_summary_defs.vh
// Register offsets, field positions, reset values and mask layout for alarm summary.
`ifndef ALARM_SUMMARY_DEFS_VH
`define ALARM_SUMMARY_DEFS_VH
// Register indices as printed; byte address is four times the index.
`define IDX_INTERRUPT_FLAGS 12'h006
`define IDX_GROUP_EVENT_SUMMARY 12'h007
`define IDX_INTERRUPT_PIN_CONTROL 12'h008
`define IDX_OPERATING_MODE 12'h009
`define IDX_GROUP_MASK 12'h00A
`define IDX_STATE_CONTROL 12'h002
`define IDX_TOH_MASK 12'h020
`define IDX_PTR_MASK 12'h021
`define IDX_POH_MASK 12'h022
`define IDX_MAP_MASK 12'h023
`define IDX_APS_MASK 12'h024
// Field positions.
`define BIT_SUMMARY_FLAG 0
`define BIT_PROTECTION_FLAG 1
`define BIT_GRP_TOH 7
`define BIT_GRP_PTR 5
`define BIT_GRP_POH 4
`define BIT_GRP_MAP 2
`define BIT_SUMMARY_PIN_EN 0
`define BIT_PROTECTION_PIN_EN 1
`define BIT_MERGE 2
`define BIT_ENCAP 0
`define BIT_ROLE 1
`define BIT_FRAMING 2
`define BIT_ISOLATE 3
`define BIT_STATE_RESET 2
// Reset values.
`define RST_PIN_CONTROL 8'h07
`define RST_OPERATING_MODE 8'h08
`define RST_GROUP_MASK 8'hB4
`define RST_STATE_CONTROL 8'h00
`define RST_ALARM_MASK 16'hFFFF
`endif

// File: hw/alarm_group_reduce.v
// Reduction of one alarm group's deltas against its per-alarm masks.
`timescale 1ns/1ns
`default_nettype none
module alarm_group_reduce #(
  parameter WIDTH = 9
) (
  input wire [WIDTH-1:0] i_delta,
  input wire [WIDTH-1:0] i_mask,
  output wire o_flag
);
  // A masked alarm contributes nothing; any live unmasked one raises the flag.
  assign o_flag = |(i_delta & ~i_mask);
endmodule // alarm_group_reduce
`default_nettype wire

// File: hw/alarm_summary_and_mode_control.v
// Alarm summary, interrupt pins, operating mode and MII isolation behind APB.
`timescale 1ns/1ns
`default_nettype none
`include "alarm_summary_defs.vh"
// What this block does
// - Protection flag from unmasked K1/K2/unstable deltas
// - Protection pin enable gates protection pin
// - Summary flag from unmasked alarm, unmasked group
// - Summary pin enable gates summary pin
// - Transport group flag from six section deltas
// - Path group flag from six path deltas
// - Mapping group flag from nine error deltas
// - Merge set: protection alarms reach summary flag
// - Merge clear: protection alarms kept from summary
// - Isolate drops MII output enable, zeroes transmit outputs
// - Register isolate equals management isolate bit
// - Framing bit: 0 SONET, 1 SDH
// - Role bit: 0 MAC, 1 PHY
// - Encapsulation bit: 0 LAPS, 1 GFP
// - State reset returns state machines to default
// - Group mask bits exclude groups from summary
module alarm_summary_and_mode_control (
  input wire i_mclk,
  input wire i_nrst,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  input wire [5:0] i_toh_delta,
  input wire [1:0] i_ptr_delta,
  input wire [5:0] i_poh_delta,
  input wire [8:0] i_map_delta,
  input wire [2:0] i_aps_delta,
  input wire i_mgmt_isolate,
  input wire [3:0] i_mii_txd,
  input wire i_mii_tx_en,
  input wire i_mii_tx_er,
  output reg o_summary_irq_pin_n,
  output reg o_protection_irq_pin_n,
  output reg o_mii_out_en,
  output reg [3:0] o_mii_txd,
  output reg o_mii_tx_en,
  output reg o_mii_tx_er,
  output reg o_sdh_mode,
  output reg o_phy_mode,
  output reg o_gfp_mode,
  output reg o_state_reset
);
  // Bus states.
  localparam ST_IDLE = 1'b0;
  localparam ST_DONE = 1'b1;

  reg state;
  reg [7:0] interrupt_pin_control;
  reg [7:0] operating_mode;
  reg [7:0] group_mask;
  reg [7:0] state_control;
  reg [15:0] toh_mask;
  reg [15:0] ptr_mask;
  reg [15:0] poh_mask;
  reg [15:0] map_mask;
  reg [15:0] aps_mask;
  reg alarm_summary_flag;
  reg protection_irq_flag;
  reg [7:0] group_event_summary;
  wire transport_overhead_group_flag;
  wire pointer_group_flag;
  wire path_overhead_group_flag;
  wire mapping_group_flag;
  wire protection_raw;
  wire transport_overhead_group_mask;
  wire merge_protection_into_summary;
  wire protection_pin_enable;
  wire summary_pin_enable;
  wire isolate;
  wire [9:0] index;
  wire write_now;
  wire setup;
  wire misaligned;
  reg [31:0] next_rdata;
  reg next_slverr;
  reg next_summary;

  // Decode a byte address into a register index; the low two bits are
  // dropped here and checked separately, so a misaligned access is refused.
  function [9:0] word_index;
    input [11:0] addr;
    begin
      word_index = addr[11:2];
    end
  endfunction

  // True when the index matches one printed register index.
  function hit;
    input [9:0] idx;
    input [11:0] reg_idx;
    begin
      hit = (idx == reg_idx[9:0]);
    end
  endfunction

  assign index = word_index(i_paddr);
  assign setup = i_psel & ~i_penable & (state == ST_IDLE);
  // Only aligned words are registers; anything else is refused.
  assign misaligned = (i_paddr[1:0] != 2'h0);
  // A write lands at the edge that completes the access phase, the same
  // edge at which the master samples pready; a bare setup writes nothing.
  assign write_now = (state == ST_DONE) & i_psel & i_penable & i_pwrite;

  // Per-group reductions share one structure; the masks are coined registers.
  alarm_group_reduce #(.WIDTH(6)) u_toh (
    .i_delta(i_toh_delta),
    .i_mask(toh_mask[5:0]),
    .o_flag(transport_overhead_group_flag)
  );
  alarm_group_reduce #(.WIDTH(2)) u_ptr (
    .i_delta(i_ptr_delta),
    .i_mask(ptr_mask[1:0]),
    .o_flag(pointer_group_flag)
  );
  alarm_group_reduce #(.WIDTH(6)) u_poh (
    .i_delta(i_poh_delta),
    .i_mask(poh_mask[5:0]),
    .o_flag(path_overhead_group_flag)
  );
  alarm_group_reduce #(.WIDTH(9)) u_map (
    .i_delta(i_map_delta),
    .i_mask(map_mask[8:0]),
    .o_flag(mapping_group_flag)
  );
  alarm_group_reduce #(.WIDTH(3)) u_aps (
    .i_delta(i_aps_delta),
    .i_mask(aps_mask[2:0]),
    .o_flag(protection_raw)
  );

  assign transport_overhead_group_mask = group_mask[`BIT_GRP_TOH];
  assign merge_protection_into_summary = interrupt_pin_control[`BIT_MERGE];
  assign protection_pin_enable = interrupt_pin_control[`BIT_PROTECTION_PIN_EN];
  assign summary_pin_enable = interrupt_pin_control[`BIT_SUMMARY_PIN_EN];
  // Either isolate source has the same effect.
  assign isolate = operating_mode[`BIT_ISOLATE] | i_mgmt_isolate;

  // Summary combines unmasked groups and, if merged, the protection alarm.
  always @*
  begin
    next_summary = (transport_overhead_group_flag &
      ~transport_overhead_group_mask) |
      (pointer_group_flag & ~group_mask[`BIT_GRP_PTR]) |
      (path_overhead_group_flag & ~group_mask[`BIT_GRP_POH]) |
      (mapping_group_flag & ~group_mask[`BIT_GRP_MAP]);
    if (merge_protection_into_summary)
    begin
      next_summary = next_summary | protection_raw;
    end
    // With merge clear the protection alarm stays out of the summary.
  end

  // Read data mux; unmapped indices answer zero with an error.
  always @*
  begin
    next_rdata = 32'h00000000;
    next_slverr = 1'b0;
    if (hit(index, `IDX_INTERRUPT_FLAGS))
    begin
      next_rdata[`BIT_SUMMARY_FLAG] = alarm_summary_flag;
      next_rdata[`BIT_PROTECTION_FLAG] = protection_irq_flag;
    end
    else if (hit(index, `IDX_GROUP_EVENT_SUMMARY))
      next_rdata[7:0] = group_event_summary;
    else if (hit(index, `IDX_INTERRUPT_PIN_CONTROL))
      next_rdata[7:0] = interrupt_pin_control;
    else if (hit(index, `IDX_OPERATING_MODE))
      next_rdata[7:0] = operating_mode;
    else if (hit(index, `IDX_GROUP_MASK))
      next_rdata[7:0] = group_mask;
    else if (hit(index, `IDX_STATE_CONTROL))
      next_rdata[7:0] = state_control;
    else if (hit(index, `IDX_TOH_MASK))
      next_rdata[15:0] = toh_mask;
    else if (hit(index, `IDX_PTR_MASK))
      next_rdata[15:0] = ptr_mask;
    else if (hit(index, `IDX_POH_MASK))
      next_rdata[15:0] = poh_mask;
    else if (hit(index, `IDX_MAP_MASK))
      next_rdata[15:0] = map_mask;
    else if (hit(index, `IDX_APS_MASK))
      next_rdata[15:0] = aps_mask;
    else
      next_slverr = 1'b1;
  end

  // APB slave: every access completes one cycle into the access phase.
  always @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state <= ST_IDLE;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h00000000;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          o_pready <= 1'b0;
          o_pslverr <= 1'b0;
          if (setup)
          begin
            state <= ST_DONE;
            o_pready <= 1'b1;
            o_pslverr <= next_slverr | misaligned;
            // A refused read returns zero rather than a neighbour's value.
            o_prdata <= (i_pwrite | misaligned) ? 32'h00000000 : next_rdata;
          end
        end
        ST_DONE:
        begin
          state <= ST_IDLE;
          o_pready <= 1'b0;
          o_pslverr <= 1'b0;
        end
        default:
        begin
          state <= ST_IDLE;
          o_pready <= 1'b0;
        end
      endcase
    end
  end

  // Writable registers. A write is applied at the access edge on which
  // pready is high, never in the setup cycle. The mode register should
  // only be changed while state reset is held; hardware does not enforce it,
  // so a mode change with state machines running takes effect at once.
  always @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      interrupt_pin_control <= `RST_PIN_CONTROL;
      operating_mode <= `RST_OPERATING_MODE;
      group_mask <= `RST_GROUP_MASK;
      state_control <= `RST_STATE_CONTROL;
      toh_mask <= `RST_ALARM_MASK;
      ptr_mask <= `RST_ALARM_MASK;
      poh_mask <= `RST_ALARM_MASK;
      map_mask <= `RST_ALARM_MASK;
      aps_mask <= `RST_ALARM_MASK;
    end
    else if (write_now && !misaligned)
    begin
      if (hit(index, `IDX_INTERRUPT_PIN_CONTROL))
        interrupt_pin_control <= {5'h00, i_pwdata[2:0]};
      if (hit(index, `IDX_OPERATING_MODE))
        operating_mode <= {4'h0, i_pwdata[3:0]};
      if (hit(index, `IDX_GROUP_MASK))
        group_mask <= i_pwdata[7:0] & `RST_GROUP_MASK;
      if (hit(index, `IDX_STATE_CONTROL))
        state_control <= {5'h00, i_pwdata[2], 2'h0};
      if (hit(index, `IDX_TOH_MASK))
        toh_mask <= {10'h000, i_pwdata[5:0]};
      if (hit(index, `IDX_PTR_MASK))
        ptr_mask <= {14'h0000, i_pwdata[1:0]};
      if (hit(index, `IDX_POH_MASK))
        poh_mask <= {10'h000, i_pwdata[5:0]};
      if (hit(index, `IDX_MAP_MASK))
        map_mask <= {7'h00, i_pwdata[8:0]};
      if (hit(index, `IDX_APS_MASK))
        aps_mask <= {13'h0000, i_pwdata[2:0]};
    end
  end

  // Flags are live reductions of the deltas, registered once. The delta
  // generators own the stickiness, so clearing happens at the source.
  // State reset holds the flags and pins at their idle value.
  always @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      alarm_summary_flag <= 1'b0;
      protection_irq_flag <= 1'b0;
      group_event_summary <= 8'h00;
      o_summary_irq_pin_n <= 1'b1;
      o_protection_irq_pin_n <= 1'b1;
    end
    else if (state_control[`BIT_STATE_RESET])
    begin
      alarm_summary_flag <= 1'b0;
      protection_irq_flag <= 1'b0;
      group_event_summary <= 8'h00;
      o_summary_irq_pin_n <= 1'b1;
      o_protection_irq_pin_n <= 1'b1;
    end
    else
    begin
      alarm_summary_flag <= next_summary;
      protection_irq_flag <= protection_raw;
      group_event_summary <= {transport_overhead_group_flag, 1'b0,
        pointer_group_flag, path_overhead_group_flag, 1'b0,
        mapping_group_flag, 2'h0};
      // A one in the enable bit lets the pin follow the flag.
      o_summary_irq_pin_n <= ~(next_summary & summary_pin_enable);
      o_protection_irq_pin_n <=
        ~(protection_raw & protection_pin_enable);
    end
  end

  // Mode outputs and MII isolation. Isolated transmit inputs read as idle so
  // downstream logic sees no frame at all.
  always @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_mii_out_en <= 1'b0;
      o_mii_txd <= 4'h0;
      o_mii_tx_en <= 1'b0;
      o_mii_tx_er <= 1'b0;
      o_sdh_mode <= 1'b0;
      o_phy_mode <= 1'b0;
      o_gfp_mode <= 1'b0;
      o_state_reset <= 1'b0;
    end
    else
    begin
      o_mii_out_en <= ~isolate;
      o_mii_txd <= isolate ? 4'h0 : i_mii_txd;
      o_mii_tx_en <= ~isolate & i_mii_tx_en;
      o_mii_tx_er <= ~isolate & i_mii_tx_er;
      o_sdh_mode <= operating_mode[`BIT_FRAMING];
      o_phy_mode <= operating_mode[`BIT_ROLE];
      o_gfp_mode <= operating_mode[`BIT_ENCAP];
      o_state_reset <= state_control[`BIT_STATE_RESET];
    end
  end
endmodule // alarm_summary_and_mode_control
`default_nettype wire

// File: bench/alarm_summary_monitor.sv
// Checker of port timing for the alarm summary and mode control block.
`timescale 1ns/1ns
`default_nettype none
module alarm_summary_monitor (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic [11:0] i_paddr,
  input wire logic [5:0] i_toh_delta,
  input wire logic [1:0] i_ptr_delta,
  input wire logic [5:0] i_poh_delta,
  input wire logic [8:0] i_map_delta,
  input wire logic [2:0] i_aps_delta,
  input wire logic i_mgmt_isolate,
  input wire logic [3:0] i_mii_txd,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_summary_irq_pin_n,
  input wire logic o_protection_irq_pin_n,
  input wire logic o_mii_out_en,
  input wire logic [3:0] o_mii_txd,
  input wire logic o_mii_tx_en,
  input wire logic o_mii_tx_er,
  input wire logic o_state_reset
);
  // Two quiet cycles are demanded so either pin latency reading holds.
  wire logic all_quiet = ~|{i_toh_delta, i_ptr_delta, i_poh_delta,
    i_map_delta, i_aps_delta};
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  ready_late_a: assert property (i_psel && !i_penable |=> o_pready)
    else $error("pready missing after setup");
  ready_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("pready longer than one cycle");
  refuse_odd_a: assert property (i_psel && !i_penable && i_paddr[1:0] != 2'b00
    |=> o_pslverr && o_prdata == 32'h0) else $error("misaligned not refused");
  prot_quiet_a: assert property (i_aps_delta == 3'h0 [*2]
    |=> o_protection_irq_pin_n) else $error("protection pin without cause");
  sum_quiet_a: assert property (all_quiet [*2]
    |=> o_summary_irq_pin_n) else $error("summary pin without cause");
  iso_zero_a: assert property (!o_mii_out_en |->
    {o_mii_txd, o_mii_tx_en, o_mii_tx_er} == 6'h00) else $error("iso leak");
  mii_copy_a: assert property (o_mii_out_en |->
    o_mii_txd == $past(i_mii_txd)) else $error("txd copy wrong");
  mgmt_iso_a: assert property (i_mgmt_isolate |=> !o_mii_out_en)
    else $error("management isolate ignored");
  state_quiet_a: assert property (o_state_reset [*3] |->
    o_summary_irq_pin_n && o_protection_irq_pin_n) else $error("pin in reset");
endmodule // alarm_summary_monitor
bind alarm_summary_and_mode_control alarm_summary_monitor u_mon (.*);
`default_nettype wire

// File: bench/host_model.sv
// Host processor model: APB master and mode programming sequence.
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input wire logic i_mclk,
  input wire logic i_pready,
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [11:0] o_paddr,
  output logic [31:0] o_pwdata
);
  // Bus idle at time zero.
  initial
  begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 12'h000;
    o_pwdata = 32'h0;
  end
  // Request held until pready is sampled; an idle edge follows each one.
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d);
  begin
    o_psel <= 1'b1;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= d;
    @(posedge i_mclk);
    o_penable <= 1'b1;
    do @(posedge i_mclk); while (i_pready !== 1'b1);
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    @(posedge i_mclk);
  end
  endtask
  // The mode word is only written with the state reset held.
  task automatic mode_wr(input logic [31:0] d);
  begin
    xfer(1'b1, 12'h008, 32'h4);
    xfer(1'b1, 12'h024, d);
  end
  endtask
endmodule // host_model
`default_nettype wire

// File: bench/tb.sv
// Self-checking bench for the alarm summary and mode control block.
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic i_mclk, i_nrst, i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
  logic i_mgmt_isolate, i_mii_tx_en, i_mii_tx_er, o_mii_out_en, o_mii_tx_en;
  logic o_mii_tx_er, o_summary_irq_pin_n, o_protection_irq_pin_n;
  logic o_sdh_mode, o_phy_mode, o_gfp_mode, o_state_reset;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata;
  logic [5:0] i_toh_delta, i_poh_delta;
  logic [1:0] i_ptr_delta;
  logic [8:0] i_map_delta;
  logic [2:0] i_aps_delta;
  logic [3:0] i_mii_txd, o_mii_txd;
  logic [25:0] dl;
  logic [32:0] expq[$];
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  int g, r;
  int base[4] = '{0, 6, 8, 14};
  int wid[4] = '{6, 2, 6, 9};
  int gbit[4] = '{7, 5, 4, 2};
  assign {i_aps_delta, i_map_delta, i_poh_delta, i_ptr_delta,
    i_toh_delta} = dl;
  alarm_summary_and_mode_control dut (.*);
  host_model host (.i_mclk(i_mclk), .i_pready(o_pready), .o_psel(i_psel),
    .o_penable(i_penable), .o_pwrite(i_pwrite), .o_paddr(i_paddr),
    .o_pwdata(i_pwdata));
  // Free running clock.
  initial
  begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
  begin
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  end
  endtask
  task automatic end_sim;
  begin
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d);
  endtask
  // The note goes in first, so the watcher finds it at the answer edge.
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
  begin
    expq.push_back(e);
    host.xfer(1'b0, a, 32'h0);
  end
  endtask
  // Watcher: read answers against notes, plus the hang limit.
  always @(posedge i_mclk)
  begin
    cyc++;
    if (i_psel && i_penable && o_pready === 1'b1 && !i_pwrite)
      chk({o_pslverr, o_prdata}, expq.pop_front());
    if (cyc > 3000)
    begin
      err_total++;
      end_sim();
    end
  end
  initial
  begin
    i_nrst = 1'b0;
    dl = 26'h0;
    i_mgmt_isolate = 1'b0;
    i_mii_txd = 4'h0;
    i_mii_tx_en = 1'b0;
    i_mii_tx_er = 1'b0;
    r = $urandom(27);
    repeat (6) @(posedge i_mclk);
    i_nrst <= 1'b1;
    @(posedge i_mclk);
    rd(12'h020, 33'h07);
    rd(12'h024, 33'h08);
    rd(12'h028, 33'hB4);
    rd(12'h0FC, 33'h100000000);
    rd(12'h019, 33'h100000000);
    $display("reset and refusal test done");
    wr(12'h028, 32'h0);
    for (g = 0; g < 4; g++)
    begin
      dl <= 26'h1 << (base[g] + $urandom % wid[g]);
      repeat (2) @(posedge i_mclk);
      rd(12'h01C, 33'h0);
      wr(12'h080 + 12'(4 * g), 32'h0);
      rd(12'h01C, 33'h1 << gbit[g]);
      rd(12'h018, 33'h1);
      wr(12'h028, 32'h1 << gbit[g]);
      rd(12'h018, 33'h0);
      wr(12'h028, 32'h0);
    end
    @(negedge i_mclk);
    chk(o_summary_irq_pin_n, 1'b0);
    @(posedge i_mclk);
    wr(12'h020, 32'h6);
    rd(12'h018, 33'h1);
    @(negedge i_mclk);
    chk(o_summary_irq_pin_n, 1'b1);
    @(posedge i_mclk);
    $display("group test done");
    wr(12'h020, 32'h7);
    wr(12'h090, 32'h0);
    dl <= 26'(($urandom % 7 + 1) << 23);
    repeat (2) @(posedge i_mclk);
    rd(12'h018, 33'h3);
    wr(12'h020, 32'h3);
    rd(12'h018, 33'h2);
    @(negedge i_mclk);
    chk(o_summary_irq_pin_n, 1'b1);
    chk(o_protection_irq_pin_n, 1'b0);
    @(posedge i_mclk);
    wr(12'h020, 32'h1);
    @(negedge i_mclk);
    chk(o_protection_irq_pin_n, 1'b1);
    @(posedge i_mclk);
    $display("protection test done");
    for (r = 0; r < 8; r++)
    begin
      host.mode_wr(r);
      rd(12'h024, r);
      @(negedge i_mclk);
      chk({o_sdh_mode, o_phy_mode, o_gfp_mode}, r);
      chk(o_state_reset, 1'b1);
      @(posedge i_mclk);
    end
    rd(12'h018, 33'h0);
    wr(12'h008, 32'h0);
    $display("mode test done");
    i_mii_txd <= 4'($urandom);
    i_mii_tx_en <= 1'b1;
    i_mii_tx_er <= 1'b1;
    repeat (2) @(posedge i_mclk);
    @(negedge i_mclk);
    chk({o_mii_out_en, o_mii_tx_en, o_mii_tx_er, o_mii_txd},
      {3'h7, i_mii_txd});
    @(posedge i_mclk);
    i_mgmt_isolate <= 1'b1;
    repeat (2) @(posedge i_mclk);
    @(negedge i_mclk);
    chk({o_mii_out_en, o_mii_tx_en, o_mii_tx_er, o_mii_txd}, 7'h0);
    @(posedge i_mclk);
    i_mgmt_isolate <= 1'b0;
    host.mode_wr(32'h8);
    wr(12'h008, 32'h0);
    @(negedge i_mclk);
    chk(o_mii_out_en, 1'b0);
    $display("isolate test done");
    end_sim();
  end
endmodule // tb
`default_nettype wire
